// >>> common/host_comm_fifo_port_map.svh
`ifndef HOST_COMM_FIFO_PORT_MAP_SVH
`define HOST_COMM_FIFO_PORT_MAP_SVH

// Register offsets inside the I/O window
`define HCF_OFS_XFER_DATA   3'h1
`define HCF_OFS_CTRL        3'h3
`define HCF_OFS_POLL_DATA   3'h5
`define HCF_OFS_POLL_STAT   3'h7

// Control/status bit positions
`define HCF_BIT_ALM_FULL    4
`define HCF_BIT_RX_EMPTY    5
`define HCF_BIT_CLR_DONE    7

// Poll status bit positions
`define HCF_BIT_BUSY        0
`define HCF_BIT_FREEZE      1
`define HCF_BIT_NOT_EMPTY   2

// Command and answer values
`define HCF_LEVEL_CMD       8'h05
`define HCF_CLR_FIRST       8'h01
`define HCF_CLR_SECOND      8'h80
`define HCF_EMPTY_READ      8'hff
`define HCF_UNMAPPED_READ   8'h00

// Almost-full level: reset value and step
`define HCF_LEVEL_RESET     9'h010
`define HCF_LEVEL_STEP      9'h010

// Clear sequence last step and rate reset value
`define HCF_CLR_LAST_STEP   3'h3
`define HCF_RATE_RESET      4'h0

`endif

// >>> common/host_comm_fifo_port_pkg.sv
package host_comm_fifo_port_pkg;

    // One host access to the I/O window
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wrData;
        logic       wr;
        logic       rd;
    } host_req_t;

    // Record rate command from firmware
    typedef struct packed {
        logic       write;
        logic [3:0] n;
    } rate_cmd_t;

    // One record byte offered by firmware
    typedef struct packed {
        logic [7:0] data;
        logic       valid;
        logic       last;
    } rec_byte_t;

    // Register state of the port, apart from the contents of its three FIFOs
    typedef struct packed {
        logic [7:0]  rdData;
        logic [7:0]  rxData;
        logic        rxValid;
        logic        txReady;
        logic        recReq;
        logic [8:0]  level;
        logic        armLevel;
        logic [2:0]  clrStep;
        logic        clrDone;
        logic [3:0]  rate;
        logic [15:0] sampleCnt;
        logic        busy;
        logic        freeze;
    } port_state_t;

endpackage : host_comm_fifo_port_pkg

// >>> core/host_comm_fifo_port.sv
// Summary of operation
// - Shared offset: read pops rx, write pushes tx
// - Control/status register at its own offset
// - Bit 5 low while receive data waits
// - Bit 4 high once write FIFO reaches level
// - Empty receive read returns ff
// - Level programmable 16 to 256, step 16
// - Write 5 then level minus 16
// - Clear: 01,80,01,80 then bit 7 set
// - Clear discards data in both directions
// - Polling idle until rate command enables it
// - Reload every 2^n samples; zero disables
// - Unread record overwritten; frozen never updated
// - Status byte: busy, freeze, not-empty bits
// - Busy high while a record loads
// - Freeze lets current record finish loading
// - Data offset write freezes, status write releases
// - Not-empty high while poll FIFO holds bytes
// - Two 512-entry buffers for host traffic
`timescale 1ns/1ps
`default_nettype none
`include "host_comm_fifo_port_map.svh"

module hcf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 512,
    localparam int AW   = $clog2(DEPTH)
) (
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire logic             clear,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] pushData,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] popData,
    output logic      [AW:0]      count
);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
    } fifo_state_t;

    fifo_state_t s_reg;
    fifo_state_t s_next;
    logic        doPush;
    logic        doPop;

    // Pointers wrap naturally, so depth must be a power of two
    always_comb begin
        s_next = s_reg;
        doPop  = pop && (s_reg.count != '0);
        doPush = push && ((s_reg.count != FULL) || doPop);
        if (clear) begin
            s_next.wrPtr = '0;
            s_next.rdPtr = '0;
            s_next.count = '0;
        end else begin
            if (doPush) begin
                s_next.mem[s_reg.wrPtr] = pushData;
                s_next.wrPtr            = s_reg.wrPtr + 1'b1;
            end
            if (doPop) begin
                s_next.rdPtr = s_reg.rdPtr + 1'b1;
            end
            if (doPush && !doPop) begin
                s_next.count = s_reg.count + 1'b1;
            end else if (doPop && !doPush) begin
                s_next.count = s_reg.count - 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign popData = s_reg.mem[s_reg.rdPtr];
    assign count   = s_reg.count;
endmodule : hcf_fifo

module host_comm_fifo_port
    import host_comm_fifo_port_pkg::*;
#(
    parameter int TX_DEPTH   = 512,
    parameter int RX_DEPTH   = 512,
    parameter int POLL_DEPTH = 256
) (
    input  wire logic      clk_sys,
    input  wire logic      nrst,
    input  wire host_req_t hostReq,
    output logic [7:0]     hostRdData,
    output logic [7:0]     fwRxData,
    output logic           fwRxValid,
    input  wire logic      fwRxReady,
    input  wire logic [7:0] fwTxData,
    input  wire logic      fwTxValid,
    output logic           fwTxReady,
    input  wire rate_cmd_t recordRateCommand,
    input  wire logic      sampleTick,
    output logic           recReq,
    input  wire rec_byte_t recByte
);
    localparam int WAW = $clog2(TX_DEPTH);
    localparam int RAW = $clog2(RX_DEPTH);
    localparam int PAW = $clog2(POLL_DEPTH);
    localparam logic [RAW:0] RX_NEAR_FULL = (RAW+1)'(RX_DEPTH - 1);

    port_state_t  s_reg;
    port_state_t  s_next;

    logic         fifoClear;
    logic         wrPush;
    logic         wrPop;
    logic [7:0]   wrHead;
    logic [WAW:0] wrCount;
    logic         rdPush;
    logic         rdPop;
    logic [7:0]   rdHead;
    logic [RAW:0] rdCount;
    logic         pollClear;
    logic         pollPush;
    logic         pollPop;
    logic [7:0]   pollHead;
    logic [PAW:0] pollCount;
    logic         rxEmpty;
    logic         almFull;
    logic         pollNotEmpty;
    logic         stageFree;
    logic         updateDue;
    logic [15:0]  periodLast;
    logic [7:0]   ctrlStatus;
    logic [7:0]   pollStatus;

    // Host to firmware characters
    hcf_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_wr_fifo (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .clear    (fifoClear),
        .push     (wrPush),
        .pushData (hostReq.wrData),
        .pop      (wrPop),
        .popData  (wrHead),
        .count    (wrCount)
    );

    // Firmware to host characters
    hcf_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rd_fifo (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .clear    (fifoClear),
        .push     (rdPush),
        .pushData (fwTxData),
        .pop      (rdPop),
        .popData  (rdHead),
        .count    (rdCount)
    );

    // Secondary record bytes
    hcf_fifo #(.WIDTH(8), .DEPTH(POLL_DEPTH)) u_poll_fifo (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .clear    (pollClear),
        .push     (pollPush),
        .pushData (recByte.data),
        .pop      (pollPop),
        .popData  (pollHead),
        .count    (pollCount)
    );

    // Status flags seen by the host
    assign rxEmpty      = (rdCount == '0);
    assign almFull      = ({{(WAW-8){1'b0}}, s_reg.level} <= wrCount);
    assign pollNotEmpty = (pollCount != '0);
    assign periodLast   = (16'h0001 << s_reg.rate) - 16'h0001;

    // Bytes as returned by a read of the two status offsets
    always_comb begin
        ctrlStatus = 8'h00;
        ctrlStatus[`HCF_BIT_RX_EMPTY] = rxEmpty;
        ctrlStatus[`HCF_BIT_ALM_FULL] = almFull;
        ctrlStatus[`HCF_BIT_CLR_DONE] = s_reg.clrDone;
        pollStatus = 8'h00;
        pollStatus[`HCF_BIT_BUSY]      = s_reg.busy;
        pollStatus[`HCF_BIT_FREEZE]    = s_reg.freeze;
        pollStatus[`HCF_BIT_NOT_EMPTY] = pollNotEmpty;
    end

    // All next-state logic of the port
    always_comb begin
        s_next        = s_reg;
        s_next.recReq = 1'b0;
        fifoClear     = 1'b0;
        wrPush        = 1'b0;
        wrPop         = 1'b0;
        rdPop         = 1'b0;
        pollClear     = 1'b0;
        pollPush      = 1'b0;
        pollPop       = 1'b0;
        stageFree     = 1'b0;
        updateDue     = 1'b0;

        // Host reads; answer is registered, one cycle later
        if (hostReq.rd) begin
            unique case (hostReq.addr)
                `HCF_OFS_XFER_DATA: begin
                    if (!rxEmpty) begin
                        s_next.rdData = rdHead;
                        rdPop         = 1'b1;
                    end else begin
                        s_next.rdData = `HCF_EMPTY_READ;
                    end
                end
                `HCF_OFS_CTRL: begin
                    s_next.rdData  = ctrlStatus;
                    s_next.clrStep = 3'h0; // Read restarts the clear sequence
                end
                `HCF_OFS_POLL_DATA: begin
                    // Reading past the record is harmless, the host gets ff
                    if (pollNotEmpty) begin
                        s_next.rdData = pollHead;
                        pollPop       = 1'b1;
                    end else begin
                        s_next.rdData = `HCF_EMPTY_READ;
                    end
                end
                `HCF_OFS_POLL_STAT: begin
                    s_next.rdData = pollStatus;
                end
                default: begin
                    s_next.rdData = `HCF_UNMAPPED_READ;
                end
            endcase
        end

        // Host writes
        if (hostReq.wr) begin
            unique case (hostReq.addr)
                `HCF_OFS_XFER_DATA: begin
                    wrPush = 1'b1; // Dropped by the FIFO if it is full and not popped in the same cycle
                end
                `HCF_OFS_CTRL: begin
                    s_next.clrDone = 1'b0;
                    if (s_reg.armLevel) begin
                        // Upper nibble only: level stays a multiple of 16
                        s_next.level    = {1'b0, hostReq.wrData[7:4], 4'h0}
                                          + `HCF_LEVEL_STEP;
                        s_next.armLevel = 1'b0;
                        s_next.clrStep  = 3'h0;
                    end else begin
                        s_next.armLevel = (hostReq.wrData == `HCF_LEVEL_CMD);
                        if (hostReq.wrData == `HCF_CLR_FIRST &&
                            !s_reg.clrStep[0]) begin
                            s_next.clrStep = s_reg.clrStep + 3'h1;
                        end else if (hostReq.wrData == `HCF_CLR_SECOND &&
                                     s_reg.clrStep[0]) begin
                            if (s_reg.clrStep == `HCF_CLR_LAST_STEP) begin
                                fifoClear      = 1'b1;
                                s_next.clrDone = 1'b1;
                                s_next.clrStep = 3'h0;
                            end else begin
                                s_next.clrStep = s_reg.clrStep + 3'h1;
                            end
                        end else begin
                            s_next.clrStep = 3'h0;
                        end
                    end
                end
                `HCF_OFS_POLL_DATA: begin
                    s_next.freeze = 1'b1;
                end
                `HCF_OFS_POLL_STAT: begin
                    s_next.freeze = 1'b0;
                end
                default: begin
                    s_next.freeze = s_reg.freeze;
                end
            endcase
        end

        // Output stage toward firmware keeps fwRx outputs registered
        stageFree = !s_reg.rxValid || fwRxReady;
        if (fifoClear) begin
            s_next.rxValid = 1'b0;
        end else if (stageFree) begin
            s_next.rxValid = (wrCount != '0);
            if (wrCount != '0) begin
                s_next.rxData = wrHead;
                wrPop         = 1'b1;
            end
        end

        // Conservative ready: one push per cycle never overflows
        s_next.txReady = (rdCount < RX_NEAR_FULL);

        // Sample divider for record reloads
        if (recordRateCommand.write) begin
            s_next.rate      = recordRateCommand.n;
            s_next.sampleCnt = 16'h0000;
        end else if (sampleTick && s_reg.rate != 4'h0) begin
            if (s_reg.sampleCnt >= periodLast) begin
                s_next.sampleCnt = 16'h0000;
                updateDue        = 1'b1;
            end else begin
                s_next.sampleCnt = s_reg.sampleCnt + 16'h0001;
            end
        end

        // Reload discards an unread record; skipped while frozen or busy
        if (updateDue && !s_reg.freeze && !s_reg.busy) begin
            pollClear      = 1'b1;
            s_next.busy    = 1'b1;
            s_next.recReq  = 1'b1;
        end

        // Loading runs to the last byte even after a freeze
        if (s_reg.busy && recByte.valid) begin
            pollPush = 1'b1;
            if (recByte.last) begin
                s_next.busy = 1'b0;
            end
        end
    end

    // Firmware push into the receive buffer
    assign rdPush = fwTxValid && s_reg.txReady;

    // State register; reset leaves polling off and level at default
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_reg       <= '0;
            s_reg.level <= `HCF_LEVEL_RESET;
            s_reg.rate  <= `HCF_RATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign hostRdData = s_reg.rdData;
    assign fwRxData   = s_reg.rxData;
    assign fwRxValid  = s_reg.rxValid;
    assign fwTxReady  = s_reg.txReady;
    assign recReq     = s_reg.recReq;
endmodule : host_comm_fifo_port

`default_nettype wire

// >>> tb/hcf_fw_model.sv
`timescale 1ns/1ps
`default_nettype none

module hcf_fw_model
    import host_comm_fifo_port_pkg::*;
#(
    parameter int REC_LEN = 4
) (
    input  wire logic       clk_sys,
    input  wire logic [7:0] fwRxData,
    input  wire logic       fwRxValid,
    output logic            fwRxReady,
    output logic [7:0]      fwTxData,
    output logic            fwTxValid,
    input  wire logic       fwTxReady,
    input  wire logic       recReq,
    output rec_byte_t       recByte,
    input  wire logic       rxStall
);
    logic [7:0] rxLog[$];
    logic [7:0] recNum;
    int         reqGap;
    int         lastGap;

    assign fwRxReady = !rxStall;

    // Sink logs bytes; gap counter times record requests
    always @(posedge clk_sys) begin
        if (fwRxValid && fwRxReady)
            rxLog.push_back(fwRxData);
        reqGap <= recReq ? 1 : reqGap + 1;
        if (recReq)
            lastGap <= reqGap;
    end

    // Record source, slow on purpose: one byte every other cycle
    initial begin
        fwTxValid = 1'b0;
        fwTxData = 8'h00;
        recByte = '{data: 8'h5a, valid: 1'b0, last: 1'b0};
        recNum = 8'h00;
        reqGap = 0;
        lastGap = 0;
        forever begin
            @(posedge clk_sys);
            if (recReq) begin
                for (int i = 0; i < REC_LEN; i++) begin
                    @(posedge clk_sys);
                    #1;
                    recByte = '{recNum * 8'h10 + i[7:0], 1'b1, i == REC_LEN - 1};
                    @(posedge clk_sys);
                    #1;
                    recByte = '{~recByte.data, 1'b0, 1'b0};
                end
                recNum = recNum + 8'h01;
            end
        end
    end

    // Byte toward the host, held until ready is seen at an edge
    task automatic send_tx(input logic [7:0] b);
        fwTxData = b;
        fwTxValid = 1'b1;
        @(posedge clk_sys);
        while (fwTxReady !== 1'b1)
            @(posedge clk_sys);
        #1;
        fwTxValid = 1'b0;
        fwTxData = ~b;
        @(posedge clk_sys);
        #1;
    endtask : send_tx
endmodule : hcf_fw_model
`default_nettype wire

// >>> tb/host_comm_fifo_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "host_comm_fifo_port_map.svh"

module host_comm_fifo_port_checker
    import host_comm_fifo_port_pkg::*;
(
    input wire logic      clk_sys,
    input wire logic      nrst,
    input wire host_req_t hostReq,
    input wire logic [7:0] hostRdData,
    input wire logic [7:0] fwRxData,
    input wire logic      fwRxValid,
    input wire logic      fwRxReady,
    input wire rate_cmd_t recordRateCommand,
    input wire logic      recReq,
    input wire rec_byte_t recByte
);
    logic rateOn;
    logic frozen;
    logic inRec;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Mirrors of rate, freeze and record-in-flight, seen from the pins only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rateOn <= 1'b0;
            frozen <= 1'b0;
            inRec  <= 1'b0;
        end else begin
            if (recordRateCommand.write)
                rateOn <= recordRateCommand.n != 4'h0;
            if (hostReq.wr && hostReq.addr == `HCF_OFS_POLL_STAT)
                frozen <= 1'b0;
            if (hostReq.wr && hostReq.addr == `HCF_OFS_POLL_DATA)
                frozen <= 1'b1;
            if (recReq)
                inRec <= 1'b1;
            else if (recByte.valid && recByte.last)
                inRec <= 1'b0;
        end
    end

    property p_recReqPulse;
        recReq |=> !recReq;
    endproperty
    a_recReqPulse: assert property (p_recReqPulse) else $error("recReq longer than one cycle");
    property p_rateGate;
        recReq |-> $past(rateOn, 2);
    endproperty
    a_rateGate: assert property (p_rateGate) else $error("record request while polling off");
    // Request rises one edge after the due cycle, so one frozen cycle there forbids it
    property p_frozenGate;
        recReq |-> !$past(frozen);
    endproperty
    a_frozenGate: assert property (p_frozenGate) else $error("record request while frozen");
    property p_busyGate;
        recReq |-> !$past(inRec);
    endproperty
    a_busyGate: assert property (p_busyGate) else $error("record request while loading");
    property p_rxHold;
        fwRxValid && !fwRxReady && !(hostReq.wr && hostReq.addr == `HCF_OFS_CTRL)
            |=> fwRxValid && $stable(fwRxData);
    endproperty
    a_rxHold: assert property (p_rxHold) else $error("firmware byte lost while stalled");
    property p_rdHold;
        !hostReq.rd |=> $stable(hostRdData);
    endproperty
    a_rdHold: assert property (p_rdHold) else $error("read data changed without a read");
    property p_unmapped;
        hostReq.rd && !hostReq.addr[0] |=> hostRdData == `HCF_UNMAPPED_READ;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_statusPad;
        hostReq.rd && hostReq.addr == `HCF_OFS_POLL_STAT |=> hostRdData[7:3] == 5'h00;
    endproperty
    a_statusPad: assert property (p_statusPad) else $error("unused status bits set");
    property p_freezeBit;
        hostReq.rd && hostReq.addr == `HCF_OFS_POLL_STAT |=> hostRdData[1] == $past(frozen);
    endproperty
    a_freezeBit: assert property (p_freezeBit) else $error("freeze bit wrong");
endmodule : host_comm_fifo_port_checker

bind host_comm_fifo_port host_comm_fifo_port_checker u_host_comm_fifo_port_checker (
    .clk_sys(clk_sys), .nrst(nrst), .hostReq(hostReq), .hostRdData(hostRdData),
    .fwRxData(fwRxData), .fwRxValid(fwRxValid), .fwRxReady(fwRxReady),
    .recordRateCommand(recordRateCommand), .recReq(recReq), .recByte(recByte));
`default_nettype wire

// >>> tb/test_host_comm_fifo_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "host_comm_fifo_port_map.svh"

module test_host_comm_fifo_port
    import host_comm_fifo_port_pkg::*;
;
    logic       clk_sys, nrst, fwRxValid, fwRxReady, fwTxValid, fwTxReady;
    logic       sampleTick, recReq, rxStall, tickOn;
    logic [7:0] hostRdData, fwRxData, fwTxData;
    logic [2:0] tickCnt;
    host_req_t  hostReq;
    rate_cmd_t  recordRateCommand;
    rec_byte_t  recByte;
    int         n_errors, comparisons, cycles;

    host_comm_fifo_port u_host_comm_fifo_port (.clk_sys(clk_sys), .nrst(nrst),
        .hostReq(hostReq), .hostRdData(hostRdData), .fwRxData(fwRxData),
        .fwRxValid(fwRxValid), .fwRxReady(fwRxReady), .fwTxData(fwTxData),
        .fwTxValid(fwTxValid), .fwTxReady(fwTxReady), .recordRateCommand(recordRateCommand),
        .sampleTick(sampleTick), .recReq(recReq), .recByte(recByte));
    hcf_fw_model u_hcf_fw_model (.clk_sys(clk_sys), .fwRxData(fwRxData),
        .fwRxValid(fwRxValid), .fwRxReady(fwRxReady), .fwTxData(fwTxData),
        .fwTxValid(fwTxValid), .fwTxReady(fwTxReady), .recReq(recReq),
        .recByte(recByte), .rxStall(rxStall));

    always #12.5 clk_sys = ~clk_sys;

    // Sample tick every eighth cycle; hang guard
    always @(posedge clk_sys) begin
        #1;
        tickCnt = tickCnt + 3'h1;
        sampleTick = tickOn && tickCnt == 3'h0;
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    // Single-cycle strobes with an idle cycle after each access
    task automatic hw(input logic [2:0] a, input logic [7:0] d);
        hostReq = '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        #1;
        hostReq.wr = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : hw

    task automatic hr(input logic [2:0] a, output logic [7:0] d);
        hostReq = '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        #1;
        hostReq.rd = 1'b0;
        d = hostRdData;
        @(posedge clk_sys);
        #1;
    endtask : hr

    // Stalled firmware: first byte parks in the stage, so m+1 writes reach level m
    task automatic fill(input int m);
        logic [7:0] s;
        int         base;
        base = u_hcf_fw_model.rxLog.size();
        rxStall = 1'b1;
        for (int i = 0; i <= m; i++) begin
            hw(`HCF_OFS_XFER_DATA, i[7:0]);
            if (i >= m - 1) begin
                hr(`HCF_OFS_CTRL, s);
                chk(s & 8'h30, i == m ? 8'h30 : 8'h20);
            end
        end
        rxStall = 1'b0;
        for (int k = 0; k < 800 && fwRxValid !== 1'b0; k++)
            @(posedge clk_sys);
        #1;
        for (int i = 0; i <= m; i++)
            chk(u_hcf_fw_model.rxLog[base + i], i[7:0]);
        hr(`HCF_OFS_CTRL, s);
        chk(s & 8'h30, 8'h20);
    endtask : fill

    initial begin
        logic [7:0] s;
        logic [7:0] cnt;
        int         lv[2] = '{1, 15};
        int         i;
        clk_sys = 1'b0;
        nrst = 1'b0;
        hostReq = '0;
        recordRateCommand = '0;
        sampleTick = 1'b0;
        rxStall = 1'b0;
        tickOn = 1'b0;
        tickCnt = 3'h0;
        n_errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (3) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        chk(hostRdData, 8'h00);
        hr(`HCF_OFS_CTRL, s);
        chk(s & 8'hb0, 8'h20);
        chk({7'h00, fwTxReady}, 8'h01);
        hr(`HCF_OFS_XFER_DATA, s);
        chk(s, `HCF_EMPTY_READ);
        hr(`HCF_OFS_POLL_DATA, s);
        chk(s, `HCF_EMPTY_READ);
        hr(3'h2, s);
        chk(s, `HCF_UNMAPPED_READ);
        hr(`HCF_OFS_POLL_STAT, s);
        chk(s, 8'h00);
        // Receive path: status before every byte
        for (i = 0; i < 3; i++)
            u_hcf_fw_model.send_tx(8'hc0 + i[7:0]);
        for (i = 0; i < 3; i++) begin
            hr(`HCF_OFS_CTRL, s);
            chk(s & 8'h20, 8'h00);
            hr(`HCF_OFS_XFER_DATA, s);
            chk(s, 8'hc0 + i[7:0]);
        end
        hr(`HCF_OFS_CTRL, s);
        chk(s & 8'h20, 8'h20);
        // Default level, then 32 and the 256 ceiling
        fill(16);
        for (int k = 0; k < 2; k++) begin
            hw(`HCF_OFS_CTRL, `HCF_LEVEL_CMD);
            hw(`HCF_OFS_CTRL, {lv[k][3:0], 4'h0});
            fill(16 * (lv[k] + 1));
        end
        // Broken sequence first, then a real clear with data both ways
        u_hcf_fw_model.send_tx(8'h77);
        rxStall = 1'b1;
        for (i = 0; i < 3; i++)
            hw(`HCF_OFS_XFER_DATA, 8'h33);
        for (i = 0; i < 4; i++)
            hw(`HCF_OFS_CTRL, i == 2 ? 8'h02 : (i[0] ? 8'h80 : 8'h01));
        hr(`HCF_OFS_CTRL, s);
        chk(s & 8'ha0, 8'h00);
        for (i = 0; i < 4; i++)
            hw(`HCF_OFS_CTRL, i[0] ? `HCF_CLR_SECOND : `HCF_CLR_FIRST);
        chk({7'h00, fwRxValid}, 8'h00);
        hr(`HCF_OFS_CTRL, s);
        chk(s & 8'hb0, 8'ha0);
        cnt = 8'(u_hcf_fw_model.rxLog.size());
        rxStall = 1'b0;
        hr(`HCF_OFS_XFER_DATA, s);
        chk(s, `HCF_EMPTY_READ);
        chk(8'(u_hcf_fw_model.rxLog.size()) - cnt, 8'h00);
        // Polling stays idle until the rate command
        tickOn = 1'b1;
        repeat (40) @(posedge clk_sys);
        #1;
        chk(u_hcf_fw_model.recNum, 8'h00);
        recordRateCommand = '{write: 1'b1, n: 4'h2};
        @(posedge clk_sys);
        #1;
        recordRateCommand.write = 1'b0;
        for (int k = 0; k < 400 && u_hcf_fw_model.recNum < 8'h03; k++)
            @(posedge clk_sys);
        #1;
        chk(8'(u_hcf_fw_model.lastGap), 8'h20);
        // Host read procedure on an already overwritten record
        s = 8'h00;
        for (int k = 0; k < 50 && s[2] !== 1'b1; k++)
            hr(`HCF_OFS_POLL_STAT, s);
        hw(`HCF_OFS_POLL_DATA, 8'h00);
        s = 8'h01;
        for (int k = 0; k < 50 && s[0] !== 1'b0; k++)
            hr(`HCF_OFS_POLL_STAT, s);
        chk(s, 8'h06);
        for (i = 0; i < 8 && s[2] === 1'b1; i++) begin
            hr(`HCF_OFS_POLL_DATA, s);
            chk(s, (u_hcf_fw_model.recNum - 8'h01) * 8'h10 + i[7:0]);
            hr(`HCF_OFS_POLL_STAT, s);
        end
        chk(i[7:0], 8'h04);
        cnt = u_hcf_fw_model.recNum;
        repeat (80) @(posedge clk_sys);
        #1;
        chk(u_hcf_fw_model.recNum, cnt);
        hw(`HCF_OFS_POLL_STAT, 8'h00);
        hr(`HCF_OFS_POLL_STAT, s);
        chk(s & 8'h02, 8'h00);
        for (int k = 0; k < 100 && u_hcf_fw_model.recNum == cnt; k++)
            @(posedge clk_sys);
        #1;
        chk(u_hcf_fw_model.recNum, cnt + 8'h01);
        // Rate zero switches polling off again; written well before the next due tick
        recordRateCommand = '{write: 1'b1, n: 4'h0};
        @(posedge clk_sys);
        #1;
        recordRateCommand.write = 1'b0;
        repeat (100) @(posedge clk_sys);
        #1;
        chk(u_hcf_fw_model.recNum, cnt + 8'h01);
        close_out();
    end
endmodule : test_host_comm_fifo_port
`default_nettype wire
